// *** pkg/timer_map.svh ***
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define APB_AW         12
`define OFS_CTRL       12'h000
`define OFS_CLKSEL     12'h004
`define OFS_CNT_LO     12'h008
`define OFS_CNT_HI     12'h00C
`define OFS_RLD_LO     12'h010
`define OFS_RLD_HI     12'h014
`define OFS_IRQ_EN     12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_HOF       7
`define CTRL_LOF       6
`define CTRL_LIE       5
`define CTRL_CAP       4
`define CTRL_SPLIT     3
`define CTRL_RUN       2
`define CTRL_EXT_HI    1
`define CTRL_EXT_LO    0
`define CK_LOW_SEL     0
`define CK_HIGH_SEL    1
`define IE_TIMER       0

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define BYTE_RST       8'h00
`define BYTE_MAX       8'hFF
`define WORD_MAX       16'hFFFF
`define WORD_ONE       16'h0001
`define BYTE_ONE       8'h01
`define DIV_SYS        12
`define DIV_RTC        8

`endif

// *** pkg/timer_pkg.sv ***
package timer_pkg;

  // external_clock_field encodings
  typedef enum logic [1:0] {
    SRC_DIV12 = 2'h0,
    SRC_RTC8  = 2'h1,
    SRC_RSVD  = 2'h2,
    SRC_COMP  = 2'h3
  } ext_clk_e;

  // source pulses after synchronising and dividing
  typedef struct packed {
    logic sys12;
    logic rtc8;
    logic comp;
  } ticks_s;

endpackage : timer_pkg

// *** verilog/timer_sync2.sv ***
`timescale 1ns/1ps
module timer_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  if (WIDTH < 1) begin : g_chk
    $error("timer_sync2: WIDTH must be at least 1");
  end

  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = din;
    nxt_s.s2 = s_ff.s1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.s2;

endmodule : timer_sync2

// *** verilog/timer_tick_gen.sv ***
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_tick_gen #(
  parameter int SYS_DIV = `DIV_SYS,
  parameter int RTC_DIV = `DIV_RTC
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // synchronised sources
  input  wire logic            rtc_sync,
  input  wire logic            comp_sync,
  // one-cycle tick pulses
  output timer_pkg::ticks_s    ticks
);

  typedef struct packed {
    logic [3:0]        div;
    logic [2:0]        rdiv;
    logic              rtc_d;
    logic              comp_d;
    timer_pkg::ticks_s tk;
  } tick_s;

  tick_s s_ff;
  tick_s nxt_s;
  logic  rtc_rise;

  if (SYS_DIV < 2 || SYS_DIV > 16 || RTC_DIV < 2 || RTC_DIV > 8) begin : g_chk
    $error("timer_tick_gen: divider out of range");
  end

  always_comb begin
    nxt_s         = s_ff;
    rtc_rise      = rtc_sync & ~s_ff.rtc_d;
    nxt_s.rtc_d   = rtc_sync;
    nxt_s.comp_d  = comp_sync;
    nxt_s.tk.comp = comp_sync & ~s_ff.comp_d;
    nxt_s.tk.sys12 = (s_ff.div == 4'(SYS_DIV - 1));
    nxt_s.div     = nxt_s.tk.sys12 ? 4'h0 : s_ff.div + 4'h1;
    nxt_s.tk.rtc8 = 1'b0;
    if (rtc_rise) begin
      nxt_s.tk.rtc8 = (s_ff.rdiv == 3'(RTC_DIV - 1));
      nxt_s.rdiv    = nxt_s.tk.rtc8 ? 3'h0 : s_ff.rdiv + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ticks = s_ff.tk;

endmodule : timer_tick_gen

// *** verilog/timer_top.sv ***
`timescale 1ns/1ps
`include "timer_map.svh"
module timer_top #(
  parameter int SYS_DIV = `DIV_SYS,
  parameter int RTC_DIV = `DIV_RTC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`APB_AW-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // asynchronous sources
  input  wire logic                rtc_clk_in,
  input  wire logic                comparator_in,
  // interrupt request
  output logic                     irq_request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [7:0]  reload_low_byte;
    logic [7:0]  reload_high_byte;
    logic        high_overflow_flag;
    logic        low_overflow_flag;
    logic        low_interrupt_enable;
    logic        capture_enable;
    logic        split_mode_select;
    logic        run_control;
    logic [1:0]  external_clock_field;
    logic        low_clock_select;
    logic        high_clock_select;
    logic        timer_interrupt_enable;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
  } st_s;

  st_s               s_ff;
  st_s               nxt_s;
  logic [1:0]        sync_out;
  timer_pkg::ticks_s ticks;
  logic              lo_tick;
  logic              hi_tick;
  logic              cap_evt;
  logic              access;
  logic              wr;
  logic [15:0]       cnt16;

  // ----------------------------------------------------------------
  // source synchronisers and tick pulses
  // ----------------------------------------------------------------
  // sync before use
  timer_sync2 #(.WIDTH(2)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({rtc_clk_in, comparator_in}),
    .dout    (sync_out)
  );

  timer_tick_gen #(.SYS_DIV(SYS_DIV), .RTC_DIV(RTC_DIV)) u_tick (
    .clk       (clk),
    .reset_n   (reset_n),
    .rtc_sync  (sync_out[1]),
    .comp_sync (sync_out[0]),
    .ticks     (ticks)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock source select
  function automatic logic pick_tick(input logic sys_sel, input logic [1:0] ext,
                                     input timer_pkg::ticks_s t);
    logic r;
    r = 1'b0;
    if (sys_sel) begin
      r = 1'b1;
    end else begin
      unique case (timer_pkg::ext_clk_e'(ext))
        timer_pkg::SRC_DIV12: r = t.sys12;
        timer_pkg::SRC_RTC8:  r = t.rtc8;
        timer_pkg::SRC_RSVD:  r = 1'b0;
        timer_pkg::SRC_COMP:  r = t.comp;
      endcase
    end
    return r;
  endfunction : pick_tick

  function automatic logic [32:0] read_decode(input logic [`APB_AW-1:0] a,
                                              input st_s s);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (a)
      `OFS_CTRL:   r[7:0] = {s.high_overflow_flag, s.low_overflow_flag,
                             s.low_interrupt_enable, s.capture_enable,
                             s.split_mode_select, s.run_control,
                             s.external_clock_field};
      `OFS_CLKSEL: r[1:0] = {s.high_clock_select, s.low_clock_select};
      `OFS_CNT_LO: r[7:0] = s.count_low_byte;
      `OFS_CNT_HI: r[7:0] = s.count_high_byte;
      `OFS_RLD_LO: r[7:0] = s.reload_low_byte;
      `OFS_RLD_HI: r[7:0] = s.reload_high_byte;
      `OFS_IRQ_EN: r[0]   = s.timer_interrupt_enable;
      default:     r[32]  = 1'b0;
    endcase
    return r;
  endfunction : read_decode

  assign lo_tick = pick_tick(s_ff.low_clock_select, s_ff.external_clock_field, ticks);
  assign hi_tick = pick_tick(s_ff.high_clock_select, s_ff.external_clock_field, ticks);
  assign cap_evt = s_ff.external_clock_field[`CTRL_EXT_HI] ? ticks.comp : ticks.rtc8;
  assign access  = psel & penable & s_ff.ready;
  assign wr      = access & pwrite;
  assign cnt16   = {s_ff.count_high_byte, s_ff.count_low_byte};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] rd;
    logic [15:0] inc16;
    logic        set_hi;
    logic        set_lo;
    logic        wr_ctrl;
    rd      = '0;
    inc16   = cnt16 + `WORD_ONE;
    set_hi  = 1'b0;
    set_lo  = 1'b0;
    wr_ctrl = wr && (paddr == `OFS_CTRL);
    nxt_s   = s_ff;

    // apb: ready in the access cycle after setup
    nxt_s.ready  = 1'b0;
    nxt_s.slverr = 1'b0;
    if (psel && !penable) begin
      rd           = read_decode(paddr, s_ff);
      nxt_s.ready  = 1'b1;
      nxt_s.slverr = ~rd[32];
      nxt_s.rdata  = pwrite ? 32'h0000_0000 : rd[31:0];
    end

    if (!s_ff.split_mode_select) begin
      if (s_ff.run_control && lo_tick) begin
        {nxt_s.count_high_byte, nxt_s.count_low_byte} = inc16;
        if (s_ff.count_low_byte == `BYTE_MAX) begin
          set_lo = 1'b1;
        end
        if (cnt16 == `WORD_MAX) begin
          set_hi = 1'b1;
          if (!s_ff.capture_enable) begin
            nxt_s.count_high_byte = s_ff.reload_high_byte;
            nxt_s.count_low_byte  = s_ff.reload_low_byte;
          end
        end
      end
    end else begin
      if (lo_tick) begin
        nxt_s.count_low_byte = s_ff.count_low_byte + `BYTE_ONE;
        if (s_ff.count_low_byte == `BYTE_MAX) begin
          set_lo = 1'b1;
          nxt_s.count_low_byte = s_ff.reload_low_byte;
        end
      end
      if (s_ff.run_control && hi_tick) begin
        nxt_s.count_high_byte = s_ff.count_high_byte + `BYTE_ONE;
        if (s_ff.count_high_byte == `BYTE_MAX) begin
          set_hi = 1'b1;
          nxt_s.count_high_byte = s_ff.reload_high_byte;
        end
      end
    end

    // software writes; a write to a count byte wins over a tick
    if (wr) begin
      unique case (paddr)
        `OFS_CTRL: begin
          nxt_s.low_interrupt_enable = pwdata[`CTRL_LIE];
          nxt_s.capture_enable       = pwdata[`CTRL_CAP];
          nxt_s.split_mode_select    = pwdata[`CTRL_SPLIT];
          nxt_s.run_control          = pwdata[`CTRL_RUN];
          nxt_s.external_clock_field = pwdata[`CTRL_EXT_HI:`CTRL_EXT_LO];
        end
        `OFS_CLKSEL: begin
          nxt_s.low_clock_select  = pwdata[`CK_LOW_SEL];
          nxt_s.high_clock_select = pwdata[`CK_HIGH_SEL];
        end
        `OFS_CNT_LO: nxt_s.count_low_byte   = pwdata[7:0];
        `OFS_CNT_HI: nxt_s.count_high_byte  = pwdata[7:0];
        `OFS_RLD_LO: nxt_s.reload_low_byte  = pwdata[7:0];
        `OFS_RLD_HI: nxt_s.reload_high_byte = pwdata[7:0];
        `OFS_IRQ_EN: nxt_s.timer_interrupt_enable = pwdata[`IE_TIMER];
        default: ;
      endcase
    end

    if (s_ff.capture_enable && cap_evt) begin
      nxt_s.reload_high_byte = s_ff.count_high_byte;
      nxt_s.reload_low_byte  = s_ff.count_low_byte;
      set_hi = 1'b1;
    end

    nxt_s.high_overflow_flag = (wr_ctrl ? pwdata[`CTRL_HOF] : s_ff.high_overflow_flag)
                               | set_hi;
    nxt_s.low_overflow_flag  = (wr_ctrl ? pwdata[`CTRL_LOF] : s_ff.low_overflow_flag)
                               | set_lo;

    nxt_s.irq = nxt_s.timer_interrupt_enable &
                (nxt_s.high_overflow_flag |
                 (nxt_s.low_interrupt_enable & nxt_s.low_overflow_flag));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata      = s_ff.rdata;
  assign pready      = s_ff.ready;
  assign pslverr     = s_ff.slverr;
  assign irq_request = s_ff.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FLAG_STICKY: assert property (
    s_ff.high_overflow_flag && !wr |=> s_ff.high_overflow_flag)
    else $error("high flag cleared without a write");

  AST_IRQ_HIGH: assert property (
    s_ff.timer_interrupt_enable && s_ff.high_overflow_flag |-> irq_request)
    else $error("high overflow did not request interrupt");

  AST_IRQ_LOW: assert property (
    s_ff.timer_interrupt_enable && s_ff.low_interrupt_enable && s_ff.low_overflow_flag
    |-> irq_request)
    else $error("low overflow did not request interrupt");

  AST_IRQ_MASKED: assert property (
    !s_ff.high_overflow_flag && !(s_ff.low_interrupt_enable && s_ff.low_overflow_flag)
    |-> !irq_request)
    else $error("interrupt without enabled source");

  AST_HOLD_STOPPED: assert property (
    !s_ff.split_mode_select && !s_ff.run_control && !wr |=> $stable(cnt16))
    else $error("count moved while stopped");

  AST_INC_ONE: assert property (
    !s_ff.split_mode_select && s_ff.run_control && lo_tick && cnt16 != `WORD_MAX && !wr
    |=> cnt16 == $past(cnt16) + `WORD_ONE)
    else $error("count did not step by one");

  AST_RELOAD16: assert property (
    !s_ff.split_mode_select && s_ff.run_control && lo_tick && cnt16 == `WORD_MAX &&
    !s_ff.capture_enable && !cap_evt && !wr
    |=> s_ff.high_overflow_flag && s_ff.low_overflow_flag &&
        cnt16 == {s_ff.reload_high_byte, s_ff.reload_low_byte})
    else $error("16-bit reload failed");

  AST_SPLIT_LO_FREE: assert property (
    s_ff.split_mode_select && !s_ff.run_control && lo_tick &&
    s_ff.count_low_byte != `BYTE_MAX && !wr
    |=> s_ff.count_low_byte == $past(s_ff.count_low_byte) + `BYTE_ONE &&
        $stable(s_ff.count_high_byte))
    else $error("split low byte not free running");

  AST_SPLIT_HI_RELOAD: assert property (
    s_ff.split_mode_select && s_ff.run_control && hi_tick &&
    s_ff.count_high_byte == `BYTE_MAX && !wr && !(s_ff.capture_enable && cap_evt)
    |=> s_ff.count_high_byte == s_ff.reload_high_byte && s_ff.high_overflow_flag)
    else $error("split high reload failed");

  AST_CAPTURE: assert property (
    s_ff.capture_enable && cap_evt && !wr
    |=> {s_ff.reload_high_byte, s_ff.reload_low_byte} == $past(cnt16) &&
        s_ff.high_overflow_flag)
    else $error("capture did not latch count");

  AST_CAP_NO_RELOAD: assert property (
    !s_ff.split_mode_select && s_ff.capture_enable && s_ff.run_control && lo_tick &&
    cnt16 == `WORD_MAX && !wr |=> cnt16 == 16'h0000)
    else $error("capture mode reloaded on overflow");

  COV_OVF16:   cover property (!s_ff.split_mode_select && $rose(s_ff.high_overflow_flag));
  COV_SPLITLO: cover property (s_ff.split_mode_select && $rose(s_ff.low_overflow_flag));
  COV_CAPTURE: cover property (s_ff.capture_enable && cap_evt);
  COV_IRQ:     cover property ($rose(irq_request));

endmodule : timer_top

// *** tb/timer_sources.sv ***
`timescale 1ns/1ps
module timer_sources #(
  parameter time RTC_HALF = 25ns
) (
  // gating from the bench
  input  wire logic rtc_en,
  // asynchronous source pins
  output logic      rtc_clk_in,
  output logic      comparator_in
);
  initial begin
    rtc_clk_in    = 1'b0;
    comparator_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // rtc oscillator, parked low when stopped
  // ----------------------------------------------------------------
  always begin
    #(RTC_HALF);
    if (rtc_en) begin
      rtc_clk_in = ~rtc_clk_in;
    end else begin
      rtc_clk_in = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // comparator output, n rising edges
  // ----------------------------------------------------------------
  task automatic pulse_comp(input int n);
    // keep pin changes off the bench clock edges
    #1ns;
    repeat (n) begin
      #40ns comparator_in = 1'b1;
      #40ns comparator_in = 1'b0;
    end
  endtask : pulse_comp
endmodule : timer_sources

// *** tb/auto_reload_timer_with_capture_tb.sv ***
`timescale 1ns/1ps
`include "timer_map.svh"
module auto_reload_timer_with_capture_tb;
  logic               clk;
  logic               reset_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [`APB_AW-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               rtc_clk_in;
  logic               comparator_in;
  logic               irq_request;
  logic               rtc_en;
  logic [31:0]        q;
  logic               err;
  logic [15:0]        v1;
  logic [15:0]        v2;
  int                 bad_count;
  int                 checks;

  localparam logic [31:0] HOF = 32'h1 << `CTRL_HOF;
  localparam logic [31:0] LOF = 32'h1 << `CTRL_LOF;
  localparam logic [31:0] LIE = 32'h1 << `CTRL_LIE;
  localparam logic [31:0] CAP = 32'h1 << `CTRL_CAP;
  localparam logic [31:0] SPL = 32'h1 << `CTRL_SPLIT;
  localparam logic [31:0] RUN = 32'h1 << `CTRL_RUN;

  timer_top dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_clk_in(rtc_clk_in), .comparator_in(comparator_in),
    .irq_request(irq_request));
  timer_sources src (.rtc_en(rtc_en), .rtc_clk_in(rtc_clk_in),
    .comparator_in(comparator_in));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic [`APB_AW-1:0] a, input logic w, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [`APB_AW-1:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [`APB_AW-1:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : rng

  task automatic rdc(input logic [`APB_AW-1:0] a, input logic [31:0] exp);
    rd(a);
    chk(q, exp);
  endtask : rdc

  task automatic rdr(input logic [`APB_AW-1:0] a, input logic [31:0] lo, input logic [31:0] hi);
    rd(a);
    rng(q, lo, hi);
  endtask : rdr

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_request !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, irq_request}, 32'h1);
  endtask : wait_irq

  task automatic cap_val(output logic [15:0] v);
    rd(`OFS_RLD_LO);
    v[7:0] = q[7:0];
    rd(`OFS_RLD_HI);
    v[15:8] = q[7:0];
  endtask : cap_val

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset and access
  task automatic t_regs();
    for (int i = 0; i < 7; i++) rdc(12'(`OFS_CTRL + 4 * i), 32'h0);
    rd(12'h01C);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    wr(`OFS_CLKSEL, 32'h3);
    wr(`OFS_CNT_LO, 32'hA5);
    wr(`OFS_CNT_HI, 32'h5A);
    repeat (40) @(posedge clk);
    rdc(`OFS_CNT_LO, 32'hA5);
    rdc(`OFS_CNT_HI, 32'h5A);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wrap16();
    wr(`OFS_RLD_LO, 32'h34);
    wr(`OFS_RLD_HI, 32'h12);
    wr(`OFS_CNT_LO, 32'hF0);
    wr(`OFS_CNT_HI, 32'hFF);
    wr(`OFS_IRQ_EN, 32'h1);
    wr(`OFS_CTRL, RUN);
    wait_irq();
    rdc(`OFS_CTRL, HOF | LOF | RUN);
    wr(`OFS_CTRL, HOF | LOF);
    rdc(`OFS_CNT_HI, 32'h12);
    rdr(`OFS_CNT_LO, 32'h34, 32'h50);
    repeat (20) @(posedge clk);
    rdc(`OFS_CTRL, HOF | LOF);
    wr(`OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_request}, 32'h0);
    $display("test wrap16 done");
  endtask : t_wrap16

  task automatic t_lowwrap();
    wr(`OFS_CNT_LO, 32'hFC);
    wr(`OFS_CNT_HI, 32'h00);
    wr(`OFS_CTRL, RUN);
    repeat (20) @(posedge clk);
    chk({31'h0, irq_request}, 32'h0);
    rdc(`OFS_CTRL, LOF | RUN);
    wr(`OFS_CTRL, LOF | LIE);
    rdc(`OFS_CNT_HI, 32'h01);
    chk({31'h0, irq_request}, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    $display("test lowwrap done");
  endtask : t_lowwrap

  task automatic t_split();
    wr(`OFS_RLD_LO, 32'h80);
    wr(`OFS_RLD_HI, 32'h80);
    wr(`OFS_CNT_LO, 32'hF8);
    wr(`OFS_CNT_HI, 32'hFE);
    wr(`OFS_CTRL, SPL | LIE);
    repeat (20) @(posedge clk);
    rdc(`OFS_CTRL, LOF | SPL | LIE);
    chk({31'h0, irq_request}, 32'h1);
    rdc(`OFS_CNT_HI, 32'hFE);
    rdr(`OFS_CNT_LO, 32'h80, 32'hA0);
    wr(`OFS_CTRL, SPL | RUN);
    repeat (10) @(posedge clk);
    rdc(`OFS_CTRL, HOF | SPL | RUN);
    rdr(`OFS_CNT_HI, 32'h80, 32'h98);
    wr(`OFS_CTRL, 32'h0);
    $display("test split done");
  endtask : t_split

  task automatic t_sources();
    wr(`OFS_CLKSEL, 32'h0);
    wr(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CNT_HI, 32'h0);
    wr(`OFS_CTRL, RUN);
    repeat (120) @(posedge clk);
    wr(`OFS_CTRL, 32'h0);
    rdr(`OFS_CNT_LO, 32'h9, 32'hB);
    wr(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CTRL, RUN | 32'h3);
    src.pulse_comp(5);
    repeat (8) @(posedge clk);
    wr(`OFS_CTRL, 32'h0);
    rdc(`OFS_CNT_LO, 32'h5);
    wr(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CTRL, RUN | 32'h1);
    rtc_en = 1'b1;
    repeat (160) @(posedge clk);
    rtc_en = 1'b0;
    repeat (8) @(posedge clk);
    wr(`OFS_CTRL, 32'h0);
    rdc(`OFS_CNT_LO, 32'h2);
    wr(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CTRL, RUN | 32'h2);
    rtc_en = 1'b1;
    src.pulse_comp(3);
    rtc_en = 1'b0;
    repeat (8) @(posedge clk);
    wr(`OFS_CTRL, 32'h0);
    rdc(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CLKSEL, 32'h2);
    wr(`OFS_CTRL, SPL | RUN | 32'h2);
    repeat (20) @(posedge clk);
    wr(`OFS_CTRL, SPL | 32'h2);
    rdc(`OFS_CNT_LO, 32'h0);
    rdr(`OFS_CNT_HI, 32'h14, 32'h18);
    $display("test sources done");
  endtask : t_sources

  task automatic t_capture();
    wr(`OFS_CLKSEL, 32'h1);
    wr(`OFS_CNT_LO, 32'h0);
    wr(`OFS_CNT_HI, 32'h0);
    wr(`OFS_CTRL, CAP | RUN | 32'h3);
    src.pulse_comp(1);
    @(posedge clk);
    wait_irq();
    rdc(`OFS_RLD_HI, 32'h0);
    rdr(`OFS_RLD_LO, 32'h08, 32'h20);
    wr(`OFS_CTRL, CAP | RUN | 32'h1);
    rtc_en = 1'b1;
    repeat (2) @(posedge clk);
    wait_irq();
    cap_val(v1);
    wr(`OFS_CTRL, CAP | RUN | 32'h1);
    repeat (2) @(posedge clk);
    wait_irq();
    cap_val(v2);
    rng({16'h0, v2 - v1}, 32'h4F, 32'h51);
    rtc_en = 1'b0;
    wr(`OFS_CTRL, CAP | RUN | 32'h1);
    wr(`OFS_CNT_LO, 32'hF0);
    wr(`OFS_CNT_HI, 32'hFF);
    repeat (20) @(posedge clk);
    rdc(`OFS_CTRL, HOF | LOF | CAP | RUN | 32'h1);
    wr(`OFS_CTRL, 32'h0);
    rdc(`OFS_CNT_HI, 32'h0);
    cap_val(v1);
    chk({16'h0, v1}, {16'h0, v2});
    $display("test capture done");
  endtask : t_capture

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    reset_n   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    rtc_en    = 1'b0;
    bad_count = 0;
    checks    = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_wrap16();
    t_lowwrap();
    t_split();
    t_sources();
    t_capture();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : auto_reload_timer_with_capture_tb
